/* if_synth_divider_timeout.sv */
// Top of IF divider, powerdown and timeout control.
// Assumes words are decoded from the serial shift register, with a
// one-cycle word_valid_i strobe on clk_i; pfd_event_i is on clk_i too.
`timescale 1ns/10ps
module if_synth_divider_timeout
   import if_synth_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic word_valid_i,
   input wire logic [23:0] word_i,
   input wire logic pfd_event_i,
   input wire logic prescale_edge_i,
   output logic counters_reset_o,
   output logic restart_o,
   output logic [3:0] swallow_o,
   output logic [13:0] binary_o,
   output logic [14:0] reference_o,
   output logic prescale_16_o,
   output logic power_off_o,
   output logic power_off_async_o,
   output logic pump_high_z_o,
   output logic pump_gain_o,
   output logic multi_pin_o,
   output logic multi_pin_oe_o
);
   typedef struct packed {
      logic rst_bit;
      logic high_z;
      logic gain;
      logic [14:0] ref_div;
      logic [3:0] swallow;
      logic [13:0] binary;
      logic prescale;
      logic power_req;
      logic power_off;
      logic async;
      logic restart_pend;
      logic restart;
      logic hold;
      logic pump_gain;
   } top_t;
   top_t s, next_s;

   logic [2:0] addr;
   logic wr_ref;
   logic wr_div;
   logic wr_toc;
   logic fa_pin;
   logic fa_oe;
   logic fa_fast;

   // Address decode on the low three bits
   assign addr = word_i[ADDR_MSB:ADDR_LSB];
   assign wr_ref = word_valid_i && (addr == ADDR_REF_CTRL);
   assign wr_div = word_valid_i && (addr == ADDR_DIV_CTRL);
   assign wr_toc = word_valid_i && (addr == ADDR_TIMEOUT_CTRL);

   if_fast_acquire u_fa (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(wr_toc),
      .value_i(word_i[TIMEOUT_MSB:TIMEOUT_LSB]),
      .pfd_event_i(pfd_event_i),
      .pin_o(fa_pin),
      .pin_oe_o(fa_oe),
      .fast_o(fa_fast)
   );

   // Register capture and control decisions
   always_comb begin
      next_s = s;
      next_s.restart = 1'b0;
      if (wr_ref) begin
         next_s.rst_bit = word_i[REF_RST_BIT];
         next_s.high_z = word_i[REF_HIGH_Z_BIT];
         next_s.gain = word_i[REF_GAIN_BIT];
         next_s.ref_div = word_i[REF_DIV_MSB:REF_DIV_LSB];
         if (s.rst_bit && !word_i[REF_RST_BIT]) begin
            next_s.restart_pend = 1'b1;
         end
      end
      if (wr_div) begin
         next_s.swallow = word_i[DIV_SWALLOW_MSB:DIV_SWALLOW_LSB];
         next_s.binary = word_i[DIV_BINARY_MSB:DIV_BINARY_LSB];
         next_s.prescale = word_i[DIV_PRESCALE_BIT];
         next_s.power_req = word_i[DIV_POWER_BIT];
      end
      // Release counters together on a prescaler edge
      if (s.restart_pend && prescale_edge_i) begin
         next_s.restart = 1'b1;
         next_s.restart_pend = 1'b0;
      end
      // Hold flag registered so the pin comes from a flip-flop
      next_s.hold = next_s.rst_bit || next_s.restart_pend;
      // High-z bit set means immediate powerdown, else wait for event
      next_s.async = next_s.high_z;
      if (!next_s.power_req) begin
         next_s.power_off = 1'b0;
      end else if (next_s.high_z || pfd_event_i) begin
         next_s.power_off = 1'b1;
      end
      next_s.pump_gain = fa_fast ? 1'b1 : s.gain;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
         s.binary <= BINARY_RESET;
         s.ref_div <= REF_RESET;
      end else begin
         s <= next_s;
      end
   end

   // Outputs from flip-flops
   assign counters_reset_o = s.hold;
   assign restart_o = s.restart;
   assign swallow_o = s.swallow;
   assign binary_o = s.binary;
   assign reference_o = s.ref_div;
   assign prescale_16_o = s.prescale;
   assign power_off_o = s.power_off;
   assign power_off_async_o = s.async;
   assign pump_high_z_o = s.high_z;
   assign pump_gain_o = s.pump_gain;
   assign multi_pin_o = fa_pin;
   assign multi_pin_oe_o = fa_oe;
endmodule

/* if_synth_pkg.sv */
// Constants for the IF synthesizer divider and timeout control block.
// Assumes 24-bit configuration words arrive already assembled and strobed.
// Contract
// - Reset bit holds swallow, binary, reference counters
// - Counters restart aligned with reference counter; code aligns the restart with prescale_edge_i
// - Swallow setting from bits 6 to 3
// - Binary setting from bits 20 to 7
// - Bit 22 selects 8/9 or 16/17 prescaler
// - Bit 23 powers IF loop down
// - Powerdown with high-z bit picks sync/async
// - Timeout 0: pin high-z, gain from bit
// - Timeout 1: pin low, high gain forced
// - Timeout 2: pin low, gain from bit
// - Timeout 3: pin high, gain from bit
// - Timeout 4..4095: low, then high-z
// - Fast-acquire lasts exactly timeout phase-detector events
// - New timeout latched on next phase-detector event
// - High gain during fast-acquire, then low gain; code then takes the gain from bit 19
// - High-z bit switches pump output asynchronously; code registers pump_high_z_o on clk_i
package if_synth_pkg;
   localparam logic [2:0] ADDR_REF_CTRL = 3'h3;
   localparam logic [2:0] ADDR_DIV_CTRL = 3'h4;
   localparam logic [2:0] ADDR_TIMEOUT_CTRL = 3'h5;
   localparam int ADDR_LSB = 0;
   localparam int ADDR_MSB = 2;
   localparam int REF_RST_BIT = 21;
   localparam int REF_HIGH_Z_BIT = 20;
   localparam int REF_GAIN_BIT = 19;
   localparam int REF_DIV_LSB = 3;
   localparam int REF_DIV_MSB = 17;
   localparam int DIV_SWALLOW_LSB = 3;
   localparam int DIV_SWALLOW_MSB = 6;
   localparam int DIV_BINARY_LSB = 7;
   localparam int DIV_BINARY_MSB = 20;
   localparam int DIV_PRESCALE_BIT = 22;
   localparam int DIV_POWER_BIT = 23;
   localparam int TIMEOUT_LSB = 3;
   localparam int TIMEOUT_MSB = 14;
   localparam logic [11:0] TOC_GP_HIGH_Z = 12'h000;
   localparam logic [11:0] TOC_MANUAL = 12'h001;
   localparam logic [11:0] TOC_GP_LOW = 12'h002;
   localparam logic [11:0] TOC_GP_HIGH = 12'h003;
   localparam logic [11:0] TOC_AUTO_MIN = 12'h004;
   localparam logic [11:0] TOC_RESET = 12'h000;
   localparam logic [13:0] BINARY_RESET = 14'h0003;
   localparam logic [14:0] REF_RESET = 15'h0003;
endpackage

/* if_fast_acquire.sv */
// Timeout counter: latches the timeout on a phase-detector event and
// drives the multi-purpose pin and fast-acquire gain request.
// Assumes pfd_event_i is a one-cycle pulse on clk_i.
`timescale 1ns/10ps
module if_fast_acquire
   import if_synth_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wr_i,
   input wire logic [11:0] value_i,
   input wire logic pfd_event_i,
   output logic pin_o,
   output logic pin_oe_o,
   output logic fast_o
);
   typedef struct packed {
      logic [11:0] pend;
      logic pend_vld;
      logic [11:0] toc;
      logic [11:0] cnt;
      logic run;
      logic pin;
      logic oe;
      logic fast;
   } fa_t;
   fa_t s, next_s;

   // Latch, count and decode
   always_comb begin
      next_s = s;
      if (wr_i) begin
         next_s.pend = value_i;
         next_s.pend_vld = 1'b1;
      end
      if (pfd_event_i) begin
         if (s.pend_vld && !wr_i) begin
            next_s.toc = s.pend;
            next_s.pend_vld = 1'b0;
            next_s.cnt = 12'h000;
            next_s.run = (s.pend >= TOC_AUTO_MIN);
         end else if (s.run) begin
            next_s.cnt = s.cnt + 12'h001;
            if (s.cnt + 12'h001 == s.toc) begin
               next_s.run = 1'b0;
            end
         end
      end
      case (next_s.toc)
         TOC_GP_HIGH_Z: begin
            next_s.pin = 1'b0;
            next_s.oe = 1'b0;
            next_s.fast = 1'b0;
         end
         TOC_MANUAL: begin
            next_s.pin = 1'b0;
            next_s.oe = 1'b1;
            next_s.fast = 1'b1;
         end
         TOC_GP_LOW: begin
            next_s.pin = 1'b0;
            next_s.oe = 1'b1;
            next_s.fast = 1'b0;
         end
         TOC_GP_HIGH: begin
            next_s.pin = 1'b1;
            next_s.oe = 1'b1;
            next_s.fast = 1'b0;
         end
         default: begin
            next_s.pin = 1'b0;
            next_s.oe = next_s.run;
            next_s.fast = next_s.run;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign pin_o = s.pin;
   assign pin_oe_o = s.oe;
   assign fast_o = s.fast;
endmodule

/* if_synth_monitor.sv */
// Port checker for the IF divider and timeout block.
// Assumes one clock, sync reset, bound to the top module.
`timescale 1ns/10ps
module if_synth_monitor
   import if_synth_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic word_valid_i,
   input wire logic [23:0] word_i,
   input wire logic pfd_event_i,
   input wire logic counters_reset_o,
   input wire logic restart_o,
   input wire logic [3:0] swallow_o,
   input wire logic [13:0] binary_o,
   input wire logic prescale_16_o,
   input wire logic power_off_o,
   input wire logic pump_high_z_o,
   input wire logic multi_pin_o,
   input wire logic multi_pin_oe_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic d3;
   logic d4;
   // Word decode per address
   assign d3 = word_valid_i && word_i[2:0] == ADDR_REF_CTRL;
   assign d4 = word_valid_i && word_i[2:0] == ADDR_DIV_CTRL;
   a_swallow_take: assert property (d4 |=> swallow_o == $past(word_i[6:3]))
      else $error("swallow mismatch");
   a_binary_take: assert property (d4 |=> binary_o == $past(word_i[20:7]))
      else $error("binary mismatch");
   a_prescale_take: assert property (d4 |=> prescale_16_o == $past(word_i[22]))
      else $error("prescale mismatch");
   a_power_clear: assert property (d4 && !word_i[23] |=> !power_off_o)
      else $error("power not cleared");
   a_power_async: assert property (d4 && word_i[23] && pump_high_z_o |=> power_off_o)
      else $error("async power late");
   a_reset_hold: assert property (d3 && word_i[21] |=> counters_reset_o)
      else $error("counters not held");
   a_restart_align: assert property ($fell(counters_reset_o) |-> restart_o)
      else $error("release without restart");
   a_high_z_take: assert property (d3 |=> pump_high_z_o == $past(word_i[20]))
      else $error("high-z mismatch");
   a_pin_waits: assert property (!pfd_event_i |=> $stable({multi_pin_o, multi_pin_oe_o}))
      else $error("pin moved without event");
endmodule
bind if_synth_divider_timeout if_synth_monitor u_if_synth_monitor (.*);

/* if_host_model.sv */
// Host model writing whole configuration words.
// Assumes calls come after reset release.
`timescale 1ns/10ps
module if_host_model (
   input wire logic clk_i,
   output logic word_valid_o,
   output logic [23:0] word_o
);
   initial begin
      word_valid_o = 1'b0;
      word_o = 24'h000000;
   end
   // One word per call; data scrambled once released
   task automatic put(input logic [2:0] a, input logic [20:0] d);
      @(negedge clk_i);
      word_o = {d, a};
      word_valid_o = 1'b1;
      @(negedge clk_i);
      word_valid_o = 1'b0;
      word_o = ~word_o;
      @(negedge clk_i);
   endtask
endmodule

/* if_synth_divider_timeout_tb_top.sv */
// Self-checking bench for the IF divider and timeout block.
// Assumes the monitor and host model are compiled first.
`timescale 1ns/10ps
module if_synth_divider_timeout_tb_top;
   import if_synth_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic pfd_event_i = 1'b0;
   logic prescale_edge_i = 1'b0;
   logic word_valid_i, counters_reset_o, restart_o, prescale_16_o, power_off_o;
   logic power_off_async_o, pump_high_z_o, pump_gain_o, multi_pin_o, multi_pin_oe_o;
   logic [23:0] word_i;
   logic [3:0] swallow_o;
   logic [13:0] binary_o;
   logic [14:0] reference_o;
   int num_errors = 0;
   int n_compared = 0;
   int n_restart = 0;
   // Rows: power, prescale, binary, swallow
   logic [19:0] rows [3] = '{{2'h1, 14'h0003, 4'h0}, {2'h0, 14'h3FFF, 4'hF},
      {2'h1, 14'h2AAA, 4'h5}};
   // Timeout 0..3: oe, driven level, gain
   logic [2:0] tmode [4] = '{3'h0, 3'h5, 3'h4, 3'h6};
   if_synth_divider_timeout u_if_synth_divider_timeout (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .word_valid_i(word_valid_i),
      .word_i(word_i),
      .pfd_event_i(pfd_event_i),
      .prescale_edge_i(prescale_edge_i),
      .counters_reset_o(counters_reset_o),
      .restart_o(restart_o),
      .swallow_o(swallow_o),
      .binary_o(binary_o),
      .reference_o(reference_o),
      .prescale_16_o(prescale_16_o),
      .power_off_o(power_off_o),
      .power_off_async_o(power_off_async_o),
      .pump_high_z_o(pump_high_z_o),
      .pump_gain_o(pump_gain_o),
      .multi_pin_o(multi_pin_o),
      .multi_pin_oe_o(multi_pin_oe_o)
   );
   if_host_model u_if_host_model (.clk_i(clk_i), .word_valid_o(word_valid_i), .word_o(word_i));
   always #2 clk_i = ~clk_i;
   // Count restart pulses between edges
   always @(negedge clk_i) begin
      if (restart_o === 1'b1) begin
         n_restart++;
      end
   end
   task automatic chk(input logic [19:0] g, input logic [19:0] e);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   // One event or prescaler pulse
   task automatic ev(input logic pre);
      @(negedge clk_i);
      pfd_event_i = !pre;
      prescale_edge_i = pre;
      @(negedge clk_i);
      pfd_event_i = 1'b0;
      prescale_edge_i = 1'b0;
      @(negedge clk_i);
   endtask
   task automatic refw(input logic r, input logic z);
      u_if_host_model.put(ADDR_REF_CTRL, {2'h0, r, z, 2'h0, 15'h0003});
   endtask
   task automatic divw(input logic p);
      u_if_host_model.put(ADDR_DIV_CTRL, {p, 2'h0, 14'h0003, 4'h0});
   endtask
   task automatic complete_run;
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(negedge clk_i);
      rst_i = 1'b0;
      chk({multi_pin_oe_o, counters_reset_o, binary_o}, 20'h00003);
      foreach (rows[i]) begin
         u_if_host_model.put(ADDR_DIV_CTRL, {rows[i][19:18], 1'b0, rows[i][17:0]});
         ev(1'b0);
         chk({power_off_o, prescale_16_o, binary_o, swallow_o}, rows[i]);
      end
      refw(1'b1, 1'b0);
      chk(counters_reset_o, 1'b1);
      refw(1'b0, 1'b0);
      chk(counters_reset_o, 1'b1);
      ev(1'b1);
      chk(counters_reset_o, 1'b0);
      chk(20'(n_restart), 20'h00001);
      divw(1'b1);
      chk(power_off_o, 1'b0);
      ev(1'b0);
      chk(power_off_o, 1'b1);
      divw(1'b0);
      refw(1'b0, 1'b1);
      divw(1'b1);
      chk({power_off_async_o, pump_high_z_o, power_off_o}, 3'h7);
      refw(1'b0, 1'b0);
      foreach (tmode[v]) begin
         u_if_host_model.put(ADDR_TIMEOUT_CTRL, 21'(v));
         ev(1'b0);
         chk({multi_pin_oe_o, multi_pin_o & multi_pin_oe_o, pump_gain_o}, tmode[v]);
      end
      // Gain bit high must reach the pump while timeout 3 stands
      u_if_host_model.put(ADDR_REF_CTRL, {4'h0, 2'h2, 15'h5A5A});
      chk({pump_gain_o, reference_o}, {1'b1, 15'h5A5A});
      refw(1'b0, 1'b0);
      u_if_host_model.put(ADDR_TIMEOUT_CTRL, 21'h4);
      chk({multi_pin_oe_o, multi_pin_o}, 2'h3);
      for (int k = 0; k < 5; k++) begin
         ev(1'b0);
         chk({multi_pin_oe_o, multi_pin_o, pump_gain_o}, k < 4 ? 3'h5 : 3'h0);
      end
      // A new value mid-run restarts the event count
      u_if_host_model.put(ADDR_TIMEOUT_CTRL, 21'h5);
      for (int k = 0; k < 8; k++) begin
         if (k == 3) begin
            u_if_host_model.put(ADDR_TIMEOUT_CTRL, 21'h4);
         end
         ev(1'b0);
         chk({multi_pin_oe_o, multi_pin_o, pump_gain_o}, k < 7 ? 3'h5 : 3'h0);
      end
      complete_run();
   end
endmodule
